// File: core/touch_event_qualifier.sv
// How it works
// (R1) Repeat off: one irq per touch/release
// (R2) Repeat on: irq at touch and each interval
// (R3) Short touch release irq needs release enable
// (R4) Repeat enable per input, resets all ones
// (R5) Block enable clear: no touch limit blocking
// (R6) Blocking: flag up to limit, hold valid set
// (R7) Refill freed slots in input 1..8 order
// (R8) Limit field codes one to four touches
// (R9) Excess touches blocked, several-touch flag set
// (R10) Ratio field scales threshold 12.5/25/37.5/100%
// (R11) Threshold from standby one in standby
// (R12) Match mode: all selected inputs over or noisy
// (R13) Count mode: count reaches selected bit count
// (R14) Pattern enable gates all pattern detection
// (R15) Pattern event blocks touches, raises irq
// (R16) Blocking lasts while pattern condition holds
// (R17) Pattern flag clears by zero write after condition
// (R18) Alert enable gates pattern alert, flag set anyway
// (R19) Per-input irq enable gates irq, resets ones
// (R20) Pattern select per input, resets all ones
// (R21) Pattern judged on one polling cycle results
// (R22) Repeat interval from period input, in samples
`timescale 1ns/1ns
`include "touch_event_qualifier_consts.svh"
module touch_event_qualifier
    import touch_event_qualifier_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // Register port
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [7:0]            reg_rdata_o,
    // Sense results, one set per sampling cycle
    input  wire logic [7:0]            touch_detect_i,
    input  wire logic [7:0]            noise_flag_i,
    input  wire logic [63:0]           delta_count_i,
    input  wire logic [63:0]           touch_threshold_i,
    input  wire logic [7:0]            standby_threshold_i,
    input  wire logic                  standby_i,
    input  wire logic                  sample_valid_i,
    input  wire logic [7:0]            repeat_period_i,
    // Qualified results
    output logic      [7:0]            touch_flags_o,
    output logic                       irq_o,
    output logic                       alert_o
);

    reg_req_t  req;
    sense_in_t sin;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
    assign sin = '{detect: touch_detect_i, noise: noise_flag_i, sample: sample_valid_i,
                   standby: standby_i};

    logic [7:0] irq_en_reg, rpt_en_reg, limit_cfg_reg, pat_cfg_reg, pat_sel_reg, rel_en_reg;
    logic [7:0] flags_reg, flags_next;
    logic [7:0] prev_flags_reg;
    logic       irq_reg, several_reg, pattern_reg, pat_cond_reg, alert_reg;
    logic [7:0] rdata_reg;

    function automatic logic [3:0] popcount8(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction

    // Register decode
    wire wr_irq_en  = req.wr && (req.addr == `OFS_IRQ_ENABLE);
    wire wr_rpt_en  = req.wr && (req.addr == `OFS_REPEAT_ENABLE);
    wire wr_limit   = req.wr && (req.addr == `OFS_TOUCH_LIMIT);
    wire wr_pat_cfg = req.wr && (req.addr == `OFS_PATTERN_CONFIG);
    wire wr_pat_sel = req.wr && (req.addr == `OFS_PATTERN_SELECT);
    wire wr_rel_en  = req.wr && (req.addr == `OFS_RELEASE_IRQ);
    wire wr_status  = req.wr && (req.addr == `OFS_STATUS);

    // Configuration fields
    wire       touch_block_enable      = limit_cfg_reg[`BIT_BLOCK_EN];
    wire [1:0] touch_count_limit       = limit_cfg_reg[`BIT_LIMIT_LO +: 2];
    wire       pattern_detect_enable   = pat_cfg_reg[`BIT_PAT_EN];
    wire [1:0] pattern_threshold_ratio = pat_cfg_reg[`BIT_RATIO_LO +: 2];
    wire       pattern_match_mode      = pat_cfg_reg[`BIT_MATCH_MODE];
    wire       pattern_alert_enable    = pat_cfg_reg[`BIT_ALERT_EN];
    wire [3:0] limit_count             = {2'b00, touch_count_limit} + 4'h1; // R8

    // Pattern threshold per input, in eighths of the base threshold
    logic [7:0] over_pat;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_thr
            wire [7:0]  base = sin.standby ? standby_threshold_i
                                           : touch_threshold_i[g*8 +: 8]; // R11
            wire [10:0] scaled = (pattern_threshold_ratio == 2'b00) ? {3'h0, base} :
                                 (pattern_threshold_ratio == 2'b01) ? {2'h0, base, 1'b0} :
                                 (pattern_threshold_ratio == 2'b10) ? ({3'h0, base} + {2'h0, base, 1'b0}) :
                                 {base, 3'h0}; // R10
            assign over_pat[g] = ({delta_count_i[g*8 +: 8], 3'h0} > scaled) || sin.noise[g];
        end
    endgenerate

    // Pattern condition on a single sample set
    wire match_hit = ((over_pat & pat_sel_reg) == pat_sel_reg); // R12
    wire count_hit = (popcount8(over_pat) >= popcount8(pat_sel_reg)); // R13
    wire pat_cond  = pattern_detect_enable && (pattern_match_mode ? match_hit : count_hit); // R14 R21
    wire pat_block = pat_cond_reg; // R16

    // Blocking: keep valid touches, refill in input order
    logic [7:0] keep, cand, grant;
    logic [3:0] room;
    always_comb begin
        keep  = prev_flags_reg & sin.detect; // R6
        // Guard against a limit lowered below the held count
        room  = (popcount8(keep) >= limit_count) ? 4'h0 : (limit_count - popcount8(keep));
        cand  = sin.detect & ~keep;
        grant = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (cand[i] && (popcount8(grant) < room)) begin
                grant[i] = 1'b1; // R7
            end
        end
        if (!touch_block_enable) begin
            flags_next = sin.detect; // R5
        end else begin
            flags_next = keep | grant;
        end
        if (pat_cond) begin
            flags_next = 8'h00; // R15 R16
        end
    end
    wire too_many = touch_block_enable && (popcount8(sin.detect) > limit_count); // R9

    // Per-input repeat state machines
    hold_state_t st_reg [8];
    logic [7:0]  rpt_cnt_reg [8];
    logic [7:0]  ev_touch, ev_rel, ev_rpt;
    generate
        for (g = 0; g < 8; g++) begin : g_rpt
            assign ev_touch[g] = flags_next[g] && !flags_reg[g];
            assign ev_rel[g]   = !flags_next[g] && flags_reg[g] && rel_en_reg[g]; // R1 R3
            assign ev_rpt[g]   = rpt_en_reg[g] && (st_reg[g] == ST_HELD) && flags_next[g]
                                 && (rpt_cnt_reg[g] + 8'h01 >= repeat_period_i)
                                 && (repeat_period_i != 8'h00); // R2 R22
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    st_reg[g]      <= ST_IDLE;
                    rpt_cnt_reg[g] <= 8'h00;
                end else if (sin.sample) begin
                    case (st_reg[g])
                        ST_IDLE: begin
                            rpt_cnt_reg[g] <= 8'h00;
                            if (flags_next[g]) st_reg[g] <= ST_HELD;
                        end
                        ST_HELD: begin
                            rpt_cnt_reg[g] <= ev_rpt[g] ? 8'h00 : rpt_cnt_reg[g] + 8'h01;
                            if (!flags_next[g]) st_reg[g] <= ST_FREE;
                        end
                        ST_FREE: begin
                            rpt_cnt_reg[g] <= 8'h00;
                            st_reg[g] <= flags_next[g] ? ST_HELD : ST_IDLE;
                        end
                        default: st_reg[g] <= ST_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    wire touch_irq = |((ev_touch | ev_rel | ev_rpt) & irq_en_reg); // R19
    wire pat_rise  = pat_cond && !pattern_reg;

    // Registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_en_reg    <= `RST_IRQ_ENABLE; // R19
            rpt_en_reg    <= `RST_REPEAT_ENABLE; // R4
            limit_cfg_reg <= `RST_TOUCH_LIMIT;
            pat_cfg_reg   <= `RST_PATTERN_CONFIG;
            pat_sel_reg   <= `RST_PATTERN_SELECT; // R20
            rel_en_reg    <= `RST_RELEASE_IRQ;
        end else begin
            if (wr_irq_en) irq_en_reg <= req.wdata;
            if (wr_rpt_en) rpt_en_reg <= req.wdata; // R4
            if (wr_limit) limit_cfg_reg <= req.wdata & 8'h8c;
            if (wr_pat_cfg) pat_cfg_reg <= req.wdata & 8'h8f;
            if (wr_pat_sel) pat_sel_reg <= req.wdata;
            if (wr_rel_en) rel_en_reg <= req.wdata;
        end
    end

    // Qualification state, updated once per sampling cycle
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg      <= 8'h00;
            prev_flags_reg <= 8'h00;
            pat_cond_reg   <= 1'b0;
            several_reg    <= 1'b0;
        end else if (sin.sample) begin
            flags_reg      <= flags_next;
            prev_flags_reg <= flags_next;
            pat_cond_reg   <= pat_cond;
            several_reg    <= too_many; // R9
        end
    end

    // Status: set wins over a clear in the same cycle
    wire pat_set   = sin.sample && pat_rise;
    wire irq_set   = sin.sample && (touch_irq || (pat_rise && !pat_block));
    wire clr_irq   = wr_status && !req.wdata[`BIT_ST_IRQ];
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_reg     <= 1'b0;
            pattern_reg <= 1'b0;
            alert_reg   <= 1'b0;
        end else begin
            if (irq_set || (sin.sample && pat_rise)) irq_reg <= 1'b1; // R15
            else if (clr_irq) irq_reg <= 1'b0;
            if (pat_set) pattern_reg <= 1'b1; // R15 R18
            else if (clr_irq && !pat_cond_reg && !pat_cond) pattern_reg <= 1'b0; // R17
            if ((sin.sample && touch_irq) || (pat_set && pattern_alert_enable)) alert_reg <= 1'b1; // R18
            else if (clr_irq) alert_reg <= 1'b0;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    wire [7:0] status_val = {5'h00, pattern_reg, several_reg, irq_reg};
    wire [7:0] rd_mux =
        (req.addr == `OFS_IRQ_ENABLE)     ? irq_en_reg :
        (req.addr == `OFS_REPEAT_ENABLE)  ? rpt_en_reg :
        (req.addr == `OFS_TOUCH_LIMIT)    ? limit_cfg_reg :
        (req.addr == `OFS_PATTERN_CONFIG) ? pat_cfg_reg :
        (req.addr == `OFS_PATTERN_SELECT) ? pat_sel_reg :
        (req.addr == `OFS_RELEASE_IRQ)    ? rel_en_reg :
        (req.addr == `OFS_STATUS)         ? status_val :
        (req.addr == `OFS_TOUCH_FLAGS)    ? flags_reg : 8'h00;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rdata_reg <= 8'h00;
        else rdata_reg <= req.rd ? rd_mux : 8'h00;
    end

    assign reg_rdata_o   = rdata_reg;
    assign touch_flags_o = flags_reg;
    assign irq_o         = irq_reg;
    assign alert_o       = alert_reg;

endmodule

// File: core/touch_event_qualifier_consts.svh
`ifndef TOUCH_EVENT_QUALIFIER_CONSTS_SVH
`define TOUCH_EVENT_QUALIFIER_CONSTS_SVH

// Register offsets
`define OFS_IRQ_ENABLE        8'h27
`define OFS_REPEAT_ENABLE     8'h28
`define OFS_TOUCH_LIMIT       8'h2a
`define OFS_PATTERN_CONFIG    8'h2b
`define OFS_PATTERN_SELECT    8'h2d
`define OFS_RELEASE_IRQ       8'h40
`define OFS_STATUS            8'h41
`define OFS_TOUCH_FLAGS       8'h42

// Reset values
`define RST_IRQ_ENABLE        8'hff
`define RST_REPEAT_ENABLE     8'hff
`define RST_TOUCH_LIMIT       8'h80
`define RST_PATTERN_CONFIG    8'h00
`define RST_PATTERN_SELECT    8'hff
`define RST_RELEASE_IRQ       8'h00

// Field positions
`define BIT_BLOCK_EN          7
`define BIT_LIMIT_LO          2
`define BIT_PAT_EN            7
`define BIT_RATIO_LO          2
`define BIT_MATCH_MODE        1
`define BIT_ALERT_EN          0
`define BIT_ST_IRQ            0
`define BIT_ST_SEVERAL        1
`define BIT_ST_PATTERN        2

// Widths
`define N_INPUTS              8
`define DELTA_W               8
`define PERIOD_W              8

`endif

// File: core/touch_event_qualifier_pkg.sv
package touch_event_qualifier_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] detect;
        logic [7:0] noise;
        logic       sample;
        logic       standby;
    } sense_in_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HELD = 3'b010,
        ST_FREE = 3'b100
    } hold_state_t;

endpackage

// File: testbench/host_model.sv
`timescale 1ns/1ns
module host_model (
    // Bus
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial addr_o = 8'h00;
    initial wdata_o = 8'h00;
    initial wr_o = 1'b0;
    initial rd_o = 1'b0;
    // Released address and data lines show the inverse so a stale value never passes
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1 q = rdata_i;
    endtask
endmodule

// File: testbench/tb_touch_event_qualifier.sv
`timescale 1ns/1ns
module tb_touch_event_qualifier;
    logic        clk = 0, rst_n = 0, sv = 0, stby = 0, wr, rd, irq, alert;
    logic [7:0]  addr, wdata, rdata, flags, q, d, det = 0, noise = 0, sthr = 8'h40, per = 8'h03;
    logic [63:0] delta = 0;
    int          fails = 0, tests_run = 0;
    logic [7:0]  ra [7] = '{8'h27, 8'h28, 8'h2a, 8'h2b, 8'h2d, 8'h40, 8'h50};
    logic [7:0]  rv [7] = '{8'hff, 8'hff, 8'h80, 8'h00, 8'hff, 8'h00, 8'h00};
    logic [31:0] pt [9] = '{32'h00ff0000, 32'h83030011, 32'h83010211, 32'h83300000, 32'h81300011,
                            32'h81100000, 32'h80300010, 32'h84300000, 32'h8c300000};
    always #10 clk = ~clk;
    host_model i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    touch_event_qualifier i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .touch_detect_i(det), .noise_flag_i(noise),
        .delta_count_i(delta), .touch_threshold_i({8{8'h40}}), .standby_threshold_i(sthr), .standby_i(stby),
        .sample_valid_i(sv), .repeat_period_i(per), .touch_flags_o(flags), .irq_o(irq), .alert_o(alert));
    function automatic logic [63:0] dv(input logic [7:0] m);
        for (int i = 0; i < 8; i++) dv[8*i +: 8] = m[i] ? 8'h10 : 8'h00;
    endfunction
    // First n touched inputs in scan order
    function automatic logic [7:0] lim(input int n, input logic [7:0] t);
        for (int i = 0; i < 8; i++) lim[i] = t[i] && ($countones(t & ((8'h01 << i) - 8'h01)) < n);
    endfunction
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wt(input logic [7:0] a, input logic [7:0] v);
        i_host.xfer(1'b1, a, v, q);
    endtask
    task automatic rg(input logic [7:0] a);
        i_host.xfer(1'b0, a, 8'h00, q);
    endtask
    task automatic smp(input logic [7:0] t, input logic [7:0] m, input logic [7:0] n);
        @(posedge clk);
        det <= t;
        delta <= dv(m);
        noise <= n;
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        det <= ~t;
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hba9d));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rg(ra[i]);
            chk("reset value", q, rv[i]);
        end
        smp(8'h03, 0, 0);
        chk("flags", flags, 8'h01);
        rg(8'h41);
        chk("several", q & 8'h02, 8'h02);
        smp(8'h02, 0, 0);
        chk("flags", flags, 8'h02);
        for (int c = 0; c < 4; c++) begin
            d = 8'($urandom);
            wt(8'h2a, 8'h80 | 8'(c << 2));
            smp(0, 0, 0);
            smp(d, 0, 0);
            chk("limited flags", flags, lim(c + 1, d));
        end
        wt(8'h2a, 8'h00);
        d = 8'($urandom);
        smp(d, 0, 0);
        chk("free flags", flags, d);
        rg(8'h42);
        chk("flags register", q, d);
        wt(8'h27, 8'h00);
        wt(8'h41, 8'h00);
        smp(0, 0, 0);
        smp(8'h04, 0, 0);
        chk("masked irq", {7'h00, irq}, 8'h00);
        wt(8'h27, 8'hff);
        repeat (4) smp(8'h04, 0, 0);
        wt(8'h41, 8'h00);
        repeat (4) smp(8'h04, 0, 0);
        chk("repeat irq", {7'h00, irq}, 8'h01);
        per <= 8'h00;
        wt(8'h41, 8'h00);
        repeat (4) smp(8'h04, 0, 0);
        chk("no period irq", {7'h00, irq}, 8'h00);
        per <= 8'h03;
        wt(8'h28, 8'h00);
        wt(8'h41, 8'h00);
        repeat (4) smp(8'h04, 0, 0);
        chk("held irq", {7'h00, irq}, 8'h00);
        wt(8'h28, 8'hff);
        wt(8'h40, 8'h04);
        wt(8'h41, 8'h00);
        smp(0, 0, 0);
        chk("release irq", {7'h00, irq}, 8'h01);
        wt(8'h2d, 8'h03);
        for (int i = 0; i < 9; i++) begin
            wt(8'h2b, pt[i][31:24]);
            smp(0, 0, 0);
            smp(0, 0, 0);
            wt(8'h41, 8'h00);
            smp(0, pt[i][23:16], pt[i][15:8]);
            rg(8'h41);
            chk("pattern flag", q & 8'h04, pt[i][4] ? 8'h04 : 8'h00);
            chk("alert", {7'h00, alert}, {7'h00, pt[i][0]});
        end
        wt(8'h2b, 8'h81);
        smp(8'h01, 8'h30, 0);
        chk("blocked", flags, 8'h00);
        chk("pattern irq", {7'h00, irq}, 8'h01);
        smp(8'h01, 8'h30, 0);
        wt(8'h41, 8'h00);
        rg(8'h41);
        chk("early clear", q & 8'h04, 8'h04);
        smp(8'h01, 0, 0);
        chk("restored", flags, 8'h01);
        smp(8'h01, 0, 0);
        wt(8'h41, 8'h00);
        rg(8'h41);
        chk("late clear", q & 8'h04, 8'h00);
        wt(8'h2b, 8'h8c);
        @(posedge clk);
        stby <= 1'b1;
        sthr <= 8'h08;
        smp(0, 8'h30, 0);
        rg(8'h41);
        chk("standby base", q & 8'h04, 8'h04);
        give_verdict();
    end
endmodule

// File: testbench/touch_event_qualifier_monitor.sv
`timescale 1ns/1ns
module touch_event_qualifier_monitor (
    // Clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Sense and results
    input wire logic [7:0] touch_detect_i,
    input wire logic       sample_valid_i,
    input wire logic [7:0] touch_flags_o,
    input wire logic       irq_o,
    input wire logic       alert_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire clr_wr = reg_wr_i && reg_addr_i == 8'h41 && !reg_wdata_i[0];
    property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_unmapped; reg_rd_i && reg_addr_i == 8'h50 |=> reg_rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_flags_chg; $changed(touch_flags_o) |-> $past(sample_valid_i); endproperty
    a_flags_chg: assert property (p_flags_chg) else $error("flags moved without sample");
    property p_flags_sub; sample_valid_i |=> (touch_flags_o & ~$past(touch_detect_i)) == 8'h00; endproperty
    a_flags_sub: assert property (p_flags_sub) else $error("flag without touch");
    property p_irq_rise; $rose(irq_o) |-> $past(sample_valid_i); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without sample");
    property p_irq_fall; $fell(irq_o) |-> $past(clr_wr); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
    property p_alert_rise; $rose(alert_o) |-> $past(sample_valid_i); endproperty
    a_alert_rise: assert property (p_alert_rise) else $error("alert rose without sample");
    property p_alert_fall; $fell(alert_o) |-> $past(clr_wr); endproperty
    a_alert_fall: assert property (p_alert_fall) else $error("alert fell without clear");
endmodule
bind touch_event_qualifier touch_event_qualifier_monitor i_mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .touch_detect_i(touch_detect_i), .sample_valid_i(sample_valid_i),
    .touch_flags_o(touch_flags_o), .irq_o(irq_o), .alert_o(alert_o));
